/* File: inc/mwc_pkg.sv */
/*
 * mwc_pkg: constants, modes and register map shared by both ends of the
 * motion wake controller.
 * assumes: one 50 MHz clock, synchronous active-low reset.
 */
package mwc_pkg;

    // ------------------------------------------------------------------
    // modes and threshold
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MWC_MODE_OFF    = 2'h0,
        MWC_MODE_SELF   = 2'h1,
        MWC_MODE_HOST   = 2'h2,
        MWC_MODE_BOTH   = 2'h3
    } mwc_mode_t;

    localparam logic [7:0]  MWC_THLD_DEFAULT  = 8'h00;
    localparam logic [7:0]  MWC_THLD_HALF_G   = 8'h80;
    localparam logic [7:0]  MWC_THLD_ONE      = 8'h01;
    localparam int          MWC_ACC_W         = 8;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          MWC_CLK_MHZ       = 50;
    localparam int          MWC_PULSE_NS      = 200;
    localparam int          MWC_PULSE_CYC     = (MWC_PULSE_NS * MWC_CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  MWC_PULSE_CNT     = 4'(MWC_PULSE_CYC);

    // ------------------------------------------------------------------
    // host-side register map (byte offsets, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0]  MWC_REG_CTRL      = 8'h00;
    localparam logic [7:0]  MWC_REG_STATUS    = 8'h04;
    localparam logic [7:0]  MWC_REG_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  MWC_REG_IRQ_MASK  = 8'h0C;
    localparam int          MWC_CTRL_MODE_LSB = 0;
    localparam int          MWC_CTRL_THLD_LSB = 8;
    localparam int          MWC_CTRL_BKUP_BIT = 16;
    localparam int          MWC_CTRL_APPLY_BIT = 17;
    localparam int          MWC_IRQ_WAKE_BIT  = 0;
    localparam int          MWC_IRQ_RESUME_BIT = 1;
    localparam logic [1:0]  MWC_IRQ_RESET     = 2'h0;
    localparam logic [31:0] MWC_WORD_ZERO     = 32'h0000_0000;

endpackage : mwc_pkg

/* File: inc/mwc_link_if.sv */
/*
 * mwc_link_if: wires between the receiver end and the host end.
 * assumes: both ends on sys_clk; the bench joins the two modules here.
 */
`timescale 1ns/100ps

interface mwc_link_if;
    import mwc_pkg::*;

    mwc_mode_t  wakeMode;        // motion_wake_mode_setting
    logic [7:0] wakeThreshold;   // motion_wake_threshold_setting
    logic       cfgApply;        // save and power cycle strobe
    logic       backupReq;       // power_mode_request_message, level
    logic [31:0] taskDuration;
    logic       extIntWakeEn;    // external_interrupt_wake_source
    logic       motionWakePin;   // motion_wake_pin, driven by the receiver
    logic       inBackup;
    logic       receiverAwake;

    modport receiver (
        input  wakeMode, wakeThreshold, cfgApply, backupReq, taskDuration, extIntWakeEn,
        output motionWakePin, inBackup, receiverAwake
    );

    modport host (
        output wakeMode, wakeThreshold, cfgApply, backupReq, taskDuration, extIntWakeEn,
        input  motionWakePin, inBackup, receiverAwake
    );

endinterface : mwc_link_if

/* File: design/mwc_receiver.sv */
/*
 * mwc_receiver: the receiver end. compares sensor acceleration against the
 * latched threshold while in backup and wakes itself and/or pulses the pin.
 * assumes: accel samples are synchronous to sys_clk; settings are latched
 * only on the host's apply strobe (stands in for a power cycle).
 */
// Notes on behaviour
// - mode zero: no self wake, no pin
// - mode one: self wake, pin silent
// - mode two: pin pulse, no self wake
// - mode three: self wake and pin pulse
// - after mode three wake, leave backup
// - threshold 1..255 maps 0 g to 1 g
// - threshold zero means half g
// - any axis at or above threshold raises interrupt
// - host puts receiver into backup first
// - host applies settings by power cycle
// - host requests backup with zero duration
// - host keeps external interrupt wake enabled
// - only host wake mode two supported; the code also pulses the pin in mode three
`timescale 1ns/100ps

module mwc_receiver
    import mwc_pkg::*;
#(
    parameter bit          SELF_WAKE_SUPPORTED = 1'b0,
    parameter int          AXES                = 3,
    parameter logic [3:0]  PULSE_CYCLES        = MWC_PULSE_CNT
)(
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    input  wire logic                       clkEn,
    input  wire logic [AXES*MWC_ACC_W-1:0]  accelMag,
    mwc_link_if.receiver                    link
);

    mwc_mode_t                  modeQ;
    logic [7:0]                 thldQ;
    logic                       backupQ;
    logic                       awakeQ;
    logic                       pinQ;
    logic [3:0]                 pulseCntQ;
    logic                       motionQ;
    logic [AXES-1:0]            axisHit;
    logic [7:0]                 effThld;
    logic                       motionRise;
    logic                       selfWake;
    logic                       hostWake;

    // ------------------------------------------------------------------
    // settings latch
    // ------------------------------------------------------------------
    // settings only on power cycle
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            modeQ <= MWC_MODE_OFF;
            thldQ <= MWC_THLD_DEFAULT;
        end
        else if (clkEn && link.cfgApply)
        begin
            modeQ <= link.wakeMode;
            thldQ <= link.wakeThreshold;
        end
    end

    // ------------------------------------------------------------------
    // detection
    // ------------------------------------------------------------------
    // zero means half g
    // code 1 is 0 g, 255 is 1 g
    assign effThld = (thldQ == MWC_THLD_DEFAULT) ? MWC_THLD_HALF_G : thldQ;

    genvar gi;
    generate
        for (gi = 0; gi < AXES; gi++)
        begin : g_axis
            // one extra bit so a full-scale sample cannot wrap to zero and miss
            assign axisHit[gi] = ({1'b0, accelMag[gi*MWC_ACC_W +: MWC_ACC_W]} + {1'b0, MWC_THLD_ONE}) >
                                 {1'b0, effThld};
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            motionQ <= 1'b0;
        else if (clkEn)
            motionQ <= backupQ && (|axisHit);
    end

    assign motionRise = backupQ && (|axisHit) && !motionQ && link.extIntWakeEn;

    // self wake gated off by default build
    assign selfWake = motionRise && SELF_WAKE_SUPPORTED &&
                      (modeQ == MWC_MODE_SELF || modeQ == MWC_MODE_BOTH);
    assign hostWake = motionRise && (modeQ == MWC_MODE_HOST || modeQ == MWC_MODE_BOTH);

    // ------------------------------------------------------------------
    // power state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            backupQ <= 1'b0;
            awakeQ  <= 1'b1;
        end
        else if (clkEn)
        begin
            if (selfWake)
            begin
                backupQ <= 1'b0;
                awakeQ  <= 1'b1;
            end
            // only an untimed backup request is honoured
            else if (link.backupReq && link.taskDuration == MWC_WORD_ZERO && !backupQ)
            begin
                backupQ <= 1'b1;
                awakeQ  <= 1'b0;
            end
            else if (!link.backupReq && backupQ)
            begin
                backupQ <= 1'b0;
                awakeQ  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // wake pin pulse
    // ------------------------------------------------------------------
    // one fixed-width pulse per event; retrigger restarts it
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pinQ      <= 1'b0;
            pulseCntQ <= 4'h0;
        end
        else if (clkEn)
        begin
            if (hostWake)
            begin
                pinQ      <= 1'b1;
                pulseCntQ <= PULSE_CYCLES - 4'h1;
            end
            else if (pulseCntQ != 4'h0)
                pulseCntQ <= pulseCntQ - 4'h1;
            else
                pinQ <= 1'b0;
        end
    end

    assign link.motionWakePin = pinQ;
    assign link.inBackup      = backupQ;
    assign link.receiverAwake = awakeQ;

endmodule : mwc_receiver

/* File: design/mwc_host.sv */
/*
 * mwc_host: the host end. software programs mode and threshold and asks
 * for backup over AHB-Lite; the wake pin raises a sticky interrupt.
 * assumes: single-word AHB-Lite transfers, OKAY only, zero wait states.
 */
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module mwc_host
    import mwc_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           reset_n,
    input  wire logic           clkEn,
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic [31:0]         hrdata,
    output logic                hreadyout,
    output logic                hresp,
    output logic                irq,
    mwc_link_if.host            link
);

    logic [31:0]    ctrlQ;
    logic [1:0]     irqStatQ;
    logic [1:0]     irqMaskQ;
    logic           applyQ;
    logic           pinQ;
    logic           awakeQ;
    logic           wrPendQ;
    logic [7:0]     wrAddrQ;
    logic [31:0]    rdataQ;
    logic           irqQ;
    logic           rdSel;
    logic [1:0]     evt;
    logic [31:0]    rdMux;

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    assign rdSel = hsel && hready && htrans[1] && !hwrite;

    always_comb
    begin
        case (haddr[7:0])
            MWC_REG_CTRL:     rdMux = ctrlQ;
            MWC_REG_STATUS:   rdMux = {29'h0, link.motionWakePin, link.receiverAwake, link.inBackup};
            MWC_REG_IRQ_STAT: rdMux = {30'h0, irqStatQ};
            MWC_REG_IRQ_MASK: rdMux = {30'h0, irqMaskQ};
            default:          rdMux = MWC_WORD_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            wrPendQ <= 1'b0;
            wrAddrQ <= 8'h00;
            rdataQ  <= MWC_WORD_ZERO;
        end
        else if (clkEn)
        begin
            wrPendQ <= hsel && hready && htrans[1] && hwrite;
            wrAddrQ <= haddr[7:0];
            if (rdSel)
                rdataQ <= rdMux;
        end
    end

    // apply pulse stands for power cycle
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ctrlQ    <= MWC_WORD_ZERO;
            irqMaskQ <= MWC_IRQ_RESET;
            applyQ   <= 1'b0;
        end
        else if (clkEn)
        begin
            applyQ <= wrPendQ && wrAddrQ == MWC_REG_CTRL && hwdata[MWC_CTRL_APPLY_BIT];
            if (wrPendQ && wrAddrQ == MWC_REG_CTRL)
                ctrlQ <= {14'h0, 1'b0, hwdata[16:0]};
            if (wrPendQ && wrAddrQ == MWC_REG_IRQ_MASK)
                irqMaskQ <= hwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------------
    // rising pin edge and backup exit; pin is registered to avoid double counts
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pinQ   <= 1'b0;
            awakeQ <= 1'b1;
        end
        else if (clkEn)
        begin
            pinQ   <= link.motionWakePin;
            awakeQ <= link.receiverAwake;
        end
    end

    assign evt[MWC_IRQ_WAKE_BIT]   = link.motionWakePin && !pinQ;
    assign evt[MWC_IRQ_RESUME_BIT] = link.receiverAwake && !awakeQ;

    // set wins over write-one-to-clear
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            irqStatQ <= MWC_IRQ_RESET;
        else if (clkEn)
            irqStatQ <= (irqStatQ & ~((wrPendQ && wrAddrQ == MWC_REG_IRQ_STAT) ? hwdata[1:0] : 2'h0)) | evt;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            irqQ <= 1'b0;
        else if (clkEn)
            irqQ <= |(irqStatQ & irqMaskQ);
    end

    assign hrdata    = rdataQ;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = irqQ;

    // ------------------------------------------------------------------
    // link drive
    // ------------------------------------------------------------------
    assign link.wakeMode      = mwc_mode_t'(ctrlQ[MWC_CTRL_MODE_LSB +: 2]);
    assign link.wakeThreshold = ctrlQ[MWC_CTRL_THLD_LSB +: 8];
    assign link.cfgApply      = applyQ;
    assign link.backupReq     = ctrlQ[MWC_CTRL_BKUP_BIT];
    assign link.taskDuration  = MWC_WORD_ZERO;
    assign link.extIntWakeEn  = 1'b1;

endmodule : mwc_host

/* File: verification/mwc_link_asserts.sv */
/*
 * mwc_link_asserts: checks on the link between the two ends.
 * assumes: the bench wires it beside the link, one clock.
 */
`timescale 1ns/100ps

module mwc_link_asserts
    import mwc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire mwc_mode_t   wakeMode,
    input wire logic [7:0]  wakeThreshold,
    input wire logic        cfgApply,
    input wire logic        backupReq,
    input wire logic [31:0] taskDuration,
    input wire logic        extIntWakeEn,
    input wire logic        motionWakePin,
    input wire logic        inBackup,
    input wire logic        receiverAwake
);
    // mode as latched by the last apply; the link mode alone may be unapplied
    logic [1:0] mode_q;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            mode_q <= 2'h0;
        else if (cfgApply)
            mode_q <= wakeMode;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    chk_pulse_width: assert property ($rose(motionWakePin) |-> motionWakePin [*8])
        else $error("wake pin pulse too short");
    chk_pin_mode: assert property ($rose(motionWakePin) |-> mode_q[1])
        else $error("wake pin pulsed in a mode without host wake");
    chk_pin_backup: assert property ($rose(motionWakePin) |-> $past(inBackup))
        else $error("wake pin pulsed outside backup");
    chk_no_self_wake: assert property ($fell(inBackup) |-> !$past(backupReq))
        else $error("receiver left backup by itself");
    chk_backup_entry: assert property (backupReq && !inBackup && taskDuration == 32'h0 |=> inBackup)
        else $error("backup request not taken");
    chk_zero_duration: assert property (backupReq |-> taskDuration == 32'h0)
        else $error("backup requested with a timed wake");
    chk_ext_wake_on: assert property (extIntWakeEn)
        else $error("external interrupt wake source disabled");
    chk_apply_single: assert property (cfgApply |=> !cfgApply)
        else $error("apply strobe longer than one cycle");

endmodule : mwc_link_asserts

/* File: verification/motion_wake_controller_bench.sv */
/*
 * motion_wake_controller_bench: both ends joined by the link, host driven over AHB-Lite.
 * assumes: a set mask bit lets that status bit through; self wake left at its default (off).
 */
`timescale 1ns/100ps

module motion_wake_controller_bench
    import mwc_pkg::*;
;
    logic        sys_clk    = 1'b0;
    logic        reset_n    = 1'b0;
    logic        hsel       = 1'b1;
    logic        hwrite     = 1'b0;
    logic [1:0]  htrans     = 2'h0;
    logic [31:0] haddr      = 32'h0;
    logic [31:0] hwdata     = 32'h0;
    logic [23:0] accelMag   = 24'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [31:0] rd;
    int          fail_count = 0;
    int          n_compared = 0;
    localparam logic [31:0] P = 32'(MWC_PULSE_CYC);

    mwc_link_if link ();

    always #10 sys_clk = ~sys_clk;

    mwc_receiver mwc_receiver_i (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(1'b1), .accelMag(accelMag),
        .link(link));
    mwc_host mwc_host_i (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(link));
    mwc_link_asserts mwc_link_asserts_i (.sys_clk(sys_clk), .reset_n(reset_n), .wakeMode(link.wakeMode),
        .wakeThreshold(link.wakeThreshold), .cfgApply(link.cfgApply), .backupReq(link.backupReq),
        .taskDuration(link.taskDuration), .extIntWakeEn(link.extIntWakeEn),
        .motionWakePin(link.motionWakePin), .inBackup(link.inBackup), .receiverAwake(link.receiverAwake));

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task tally_and_finish;
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // one single transfer; entered just after a rising edge
    task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", 32'(hresp), 32'h0);
    endtask : ahb

    function logic [31:0] ctrl(logic [1:0] m, logic [7:0] t, logic b, logic ap);
        return {14'h0, ap, b, t, 6'h0, m};
    endfunction : ctrl

    // apply settings, then ask for backup
    task setup(input logic [1:0] m, input logic [7:0] t);
        ahb(MWC_REG_CTRL, 1'b1, ctrl(m, t, 1'b0, 1'b1));
        ahb(MWC_REG_CTRL, 1'b1, ctrl(m, t, 1'b1, 1'b0));
        repeat (3) @(negedge sys_clk);
        check("inBackup", 32'(link.inBackup), 32'h1);
        @(posedge sys_clk);
    endtask : setup

    // one motion event on one axis, pin cycles counted
    task move(input int ax, input logic [7:0] v, input logic [31:0] exp);
        int n;
        n = 0;
        accelMag <= 24'(v) << (8 * ax);
        repeat (14)
        begin
            @(negedge sys_clk);
            if (link.motionWakePin === 1'b1)
                n++;
        end
        @(posedge sys_clk);
        accelMag <= 24'h0;
        repeat (3) @(posedge sys_clk);
        check("pinCycles", 32'(n), exp);
    endtask : move

    initial
    begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        ahb(MWC_REG_STATUS, 1'b0, 32'h0);
        check("statusReset", rd, 32'h2);
        ahb(8'h10, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            setup(2'(m), 8'h40);
            move(0, 8'h40, m[1] ? P : 32'h0);
            check("stayAsleep", 32'(link.inBackup), 32'h1);
        end
        setup(2'h2, 8'h40);
        move(1, 8'h3F, 32'h0);
        move(2, 8'h40, P);
        setup(2'h2, 8'h00);
        move(0, 8'h7F, 32'h0);
        move(1, 8'h80, P);
        setup(2'h2, 8'h01);
        move(2, 8'h00, 32'h0);
        ahb(MWC_REG_CTRL, 1'b1, ctrl(2'h0, 8'hFF, 1'b1, 1'b0));
        move(0, 8'h01, P);
        check("irqAllMasked", 32'(irq), 32'h0);
        ahb(MWC_REG_IRQ_STAT, 1'b0, 32'h0);
        check("irqStatBoth", rd, 32'h3);
        ahb(MWC_REG_IRQ_STAT, 1'b1, 32'h3);
        ahb(MWC_REG_IRQ_MASK, 1'b1, 32'h1);
        move(1, 8'h01, P);
        check("irqUp", 32'(irq), 32'h1);
        ahb(MWC_REG_IRQ_STAT, 1'b0, 32'h0);
        check("irqStat", rd, 32'h1);
        ahb(MWC_REG_IRQ_STAT, 1'b1, 32'h1);
        @(posedge sys_clk);
        @(negedge sys_clk);
        check("irqClr", 32'(irq), 32'h0);
        @(posedge sys_clk);
        ahb(MWC_REG_CTRL, 1'b1, ctrl(2'h2, 8'h01, 1'b0, 1'b0));
        repeat (2) @(posedge sys_clk);
        move(0, 8'h01, 32'h0);
        ahb(MWC_REG_STATUS, 1'b0, 32'h0);
        check("statusAwake", rd, 32'h2);
        ahb(MWC_REG_IRQ_STAT, 1'b0, 32'h0);
        check("irqStatResume", rd, 32'h2);
        check("irqResumeMasked", 32'(irq), 32'h0);
        tally_and_finish();
    end

    // a hang ends the run the same way
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish();
    end

endmodule : motion_wake_controller_bench
